//--- hdl/arl_pkg.sv
// arl_pkg: shared constants and types for the ready-link/trim block.
// assumes one 200 MHz clock; the register interface lives elsewhere.
package arl_pkg;
  localparam int NCH = 8;
  localparam int DW = 24;
  localparam int PHW = 12;
  localparam int CLK_MHZ = 200;
  // gain path latency in modulator clock periods
  localparam logic [4:0] GAIN_DELAY_TICKS = 5'h18;
  localparam logic [2:0] DEC_OSR32 = 3'h0;
  // at the lowest ratio only the top 17 offset bits count
  localparam int OSR32_KEEP = 17;
  localparam logic [DW-1:0] OSR32_MASK =
    ~((24'h1 << (DW - OSR32_KEEP)) - 24'h1);
  localparam logic [DW-1:0] SAT24_MAX = 24'h7fffff;
  localparam logic [DW-1:0] SAT24_MIN = 24'h800000;
  localparam logic [15:0] SAT16_MAX = 16'h7fff;
  localparam logic [15:0] SAT16_MIN = 16'h8000;
  localparam logic [NCH-1:0] FLAGS_RESET = 8'hff;
  localparam logic [DW-1:0] TRIM_RESET = 24'h000000;
  localparam logic [DW:0] GAIN_UNITY = 25'h0800000;
  localparam int GAIN_FRAC = 23;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {
    ARL_IDLE = 2'b00,
    ARL_HOLD = 2'b01
  } arl_state_t;

  typedef struct packed {
    logic [NCH-1:0] valid;
    logic [NCH-1:0][DW-1:0] data;
  } arl_conv_t;

  typedef struct packed {
    logic ready_link_select;
    logic offset_trim_enable;
    logic gain_trim_enable;
    logic external_clock_select;
    logic res16;
    logic [2:0] decimation_ratio;
  } arl_cfg_t;

  typedef struct packed {
    logic wr;
    logic gain_sel;
    logic [2:0] ch;
    logic [DW-1:0] word;
  } arl_trim_wr_t;

  typedef struct packed {
    logic [2:0] ch;
    logic [DW-1:0] word;
  } arl_sample_t;
endpackage

//--- hdl/arl_ready_link.sv
// arl_ready_link: ready-pin link, per-channel ready flags, offset and
// gain trim with saturation, oscillator select, and a sample FIFO.
// assumes conversion pulses arrive already phase-delayed per channel.
`timescale 1ns/1ps
`default_nettype none

module arl_fifo #(
  parameter int W = 27,
  parameter int D = 16
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // synchronised reset
  input wire logic i_valid, // write request
  output logic o_ready, // not full
  input wire logic [W-1:0] i_data, // write word
  output logic o_valid, // not empty
  input wire logic i_ready, // reader accepts
  output logic [W-1:0] o_data // head word
);
  localparam int AW = $clog2(D);
  // pointers carry one extra bit so full and empty can be told apart
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } arl_fifo_st_t;
  logic [W-1:0] mem [D];
  arl_fifo_st_t fst;
  arl_fifo_st_t next_fst;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (fst.wp[AW] != fst.rp[AW]) &&
    (fst.wp[AW-1:0] == fst.rp[AW-1:0]);
  assign empty = (fst.wp == fst.rp);
  assign push = i_valid && !full;
  assign pop = i_ready && !empty;
  assign o_ready = !full;
  assign o_valid = !empty;
  assign o_data = mem[fst.rp[AW-1:0]];

  always_comb begin
    next_fst = fst;
    if (push) begin
      next_fst.wp = fst.wp + 1'b1;
    end
    if (pop) begin
      next_fst.rp = fst.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fst <= '0;
    end else begin
      fst <= next_fst;
    end
  end

  // storage carries no reset; pointers define what is valid
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[fst.wp[AW-1:0]] <= i_data;
    end
  end
endmodule

module arl_ready_link
  import arl_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic i_clk, // 200 MHz clock
  input wire logic i_arst_n, // async reset, active low
  input wire arl_conv_t i_conv, // per-channel result pulses and codes
  input wire logic [NCH-1:0] i_chan_off, // channel in reset/shutdown
  input wire logic [3:0][PHW-1:0] i_pair_delay_regs, // pair phases
  input wire arl_cfg_t i_cfg, // configuration bits
  input wire logic i_mod_tick, // one pulse per modulator clock
  input wire arl_trim_wr_t i_trim, // trim word write
  input wire logic i_status_rd, // status register read pulse
  output logic o_ready_pin_n, // shared ready pin, low pulse
  output logic [NCH-1:0] o_channel_ready_flags, // 1 = not updated
  output logic [NCH-1:0][DW-1:0] o_chan_data, // latched outputs
  output logic [NCH-1:0][DW-1:0] o_offset_trim, // stored offsets
  output logic [NCH-1:0][DW-1:0] o_gain_trim, // stored gains
  output logic o_osc_enable, // crystal oscillator on
  output logic o_osc_bypass, // digital input buffer on
  output logic o_crystal_out_pin_pulldown, // pull second pin low
  output logic o_stream_valid, // sample available
  input wire logic i_stream_ready, // host takes sample
  output arl_sample_t o_stream // channel and word
);
  typedef struct packed {
    arl_state_t state;
    logic [4:0] cnt;
    logic gain_lat;
    logic [NCH-1:0][DW-1:0] raw;
    logic [NCH-1:0][DW-1:0] stage;
    logic [NCH-1:0][DW-1:0] out;
    logic [NCH-1:0][DW-1:0] offset_trim;
    logic [NCH-1:0][DW-1:0] gain_trim;
    logic [NCH-1:0] pend;
    logic [NCH-1:0] push;
    logic [NCH-1:0] flags;
    logic pin_n;
    logic osc_en;
    logic bypass;
  } arl_st_t;

  localparam arl_st_t ST_RESET = '{
    state: ARL_IDLE, cnt: 5'h00, gain_lat: 1'b0,
    raw: '0, stage: '0, out: '0,
    offset_trim: {NCH{TRIM_RESET}}, gain_trim: {NCH{TRIM_RESET}},
    pend: '0, push: '0, flags: FLAGS_RESET,
    pin_n: 1'b1, osc_en: 1'b1, bypass: 1'b0
  };

  arl_st_t st;
  arl_st_t next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  logic fifo_ready;
  logic [2:0] push_ch;

  // even channel delay is its pair phase, odd channels are the reference
  function automatic logic [2:0] arl_lag(
    input logic [3:0][PHW-1:0] ph,
    input logic [NCH-1:0] act
  );
    logic signed [PHW:0] best;
    logic signed [PHW:0] d;
    logic [2:0] idx;
    best = {1'b1, {PHW{1'b0}}};
    idx = 3'h1;
    for (int c = 0; c < NCH; c++) begin
      d = (c % 2 == 1) ? 13'sd0 : 13'($signed(ph[c/2]));
      if (act[c] && d > best) begin
        best = d;
        idx = 3'(c);
      end
    end
    return idx;
  endfunction

  function automatic logic [2:0] arl_first(input logic [NCH-1:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (m[c]) begin
        idx = 3'(c);
      end
    end
    return idx;
  endfunction

  function automatic logic [DW-1:0] arl_correct(
    input logic [DW-1:0] raw,
    input logic [DW-1:0] off,
    input logic [DW-1:0] gain,
    input logic en_off,
    input logic en_gain,
    input logic act,
    input logic osr32,
    input logic res16
  );
    logic [DW-1:0] o;
    logic signed [DW:0] s;
    logic signed [DW:0] m;
    logic signed [2*DW+1:0] p;
    logic signed [DW+2:0] r;
    logic signed [DW-6:0] t;
    logic [DW-1:0] y;
    o = osr32 ? (off & OSR32_MASK) : off;
    s = 25'($signed(raw));
    if (en_off && act) begin
      s = 25'($signed(raw)) + 25'($signed(o));
    end
    m = $signed(GAIN_UNITY) + 25'($signed(gain));
    p = s * m;
    r = 27'(s);
    if (en_gain && act) begin
      r = p[2*DW+1:GAIN_FRAC];
    end
    if (res16) begin
      t = r[DW+2:8];
      if (t > 19'sh07fff) begin
        y = {SAT16_MAX, 8'h00};
      end else if (t < -19'sh08000) begin
        y = {SAT16_MIN, 8'h00};
      end else begin
        y = {t[15:0], 8'h00};
      end
    end else if (r > 27'sh07fffff) begin
      y = SAT24_MAX;
    end else if (r < -27'sh0800000) begin
      y = SAT24_MIN;
    end else begin
      y = r[DW-1:0];
    end
    return y;
  endfunction

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_comb begin
    logic [NCH-1:0] act;
    logic [NCH-1:0] cap;
    logic [NCH-1:0] rel;
    logic [2:0] lag;
    logic gain_now;
    logic osr32;
    act = ~i_chan_off;
    lag = arl_lag(i_pair_delay_regs, act);
    gain_now = i_cfg.gain_trim_enable;
    osr32 = (i_cfg.decimation_ratio == DEC_OSR32);
    next_st = st;
    rel = '0;
    cap = '0;
    push_ch = arl_first(st.push);

    for (int c = 0; c < NCH; c++) begin
      if (i_conv.valid[c]) begin
        next_st.raw[c] = i_conv.data[c];
      end
    end

    // linked mode waits for the lagging channel, then takes all active
    if (i_cfg.ready_link_select) begin
      cap = i_conv.valid[lag] ? act : '0;
    end else begin
      cap = i_conv.valid;
    end

    // trim words stay stored whatever the enables say
    for (int c = 0; c < NCH; c++) begin
      if (cap[c]) begin
        next_st.stage[c] = arl_correct(next_st.raw[c], st.offset_trim[c],
          st.gain_trim[c], i_cfg.offset_trim_enable, gain_now, act[c],
          osr32, i_cfg.res16);
      end
    end

    case (st.state)
      ARL_IDLE: begin
        if (cap != '0 && gain_now) begin
          next_st.state = ARL_HOLD;
          next_st.cnt = 5'h00;
          next_st.pend = cap;
          next_st.gain_lat = 1'b1;
        end else begin
          rel = cap;
          next_st.gain_lat = 1'b0;
        end
      end
      ARL_HOLD: begin
        next_st.pend = st.pend | cap;
        if (i_mod_tick) begin
          next_st.cnt = st.cnt + 5'h01;
          if (st.cnt == GAIN_DELAY_TICKS - 5'h01) begin
            rel = next_st.pend;
            next_st.pend = '0;
            next_st.state = ARL_IDLE;
          end
        end
      end
      default: begin
        next_st.state = ARL_IDLE;
        next_st.pend = '0;
      end
    endcase

    // a read sets flags, a same-cycle update still clears them
    if (i_status_rd) begin
      next_st.flags = FLAGS_RESET;
    end
    for (int c = 0; c < NCH; c++) begin
      if (rel[c]) begin
        next_st.out[c] = next_st.stage[c];
        next_st.flags[c] = 1'b0;
      end
    end
    next_st.push = (st.push | rel);
    if (st.push != '0 && fifo_ready) begin
      next_st.push[push_ch] = rel[push_ch];
    end

    if (i_cfg.ready_link_select) begin
      next_st.pin_n = !(rel != '0);
    end else begin
      next_st.pin_n = !(rel[0] || rel[1]);
    end

    next_st.osc_en = !i_cfg.external_clock_select;
    next_st.bypass = i_cfg.external_clock_select;

    if (i_trim.wr) begin
      if (i_trim.gain_sel) begin
        next_st.gain_trim[i_trim.ch] = i_trim.word;
      end else begin
        next_st.offset_trim[i_trim.ch] = i_trim.word;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  arl_fifo #(
    .W($bits(arl_sample_t)),
    .D(DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_valid(st.push != '0),
    .o_ready(fifo_ready),
    .i_data({push_ch, st.out[push_ch]}),
    .o_valid(o_stream_valid),
    .i_ready(i_stream_ready),
    .o_data(o_stream)
  );

  assign o_ready_pin_n = st.pin_n;
  assign o_channel_ready_flags = st.flags;
  assign o_chan_data = st.out;
  assign o_offset_trim = st.offset_trim;
  assign o_gain_trim = st.gain_trim;
  assign o_osc_enable = st.osc_en;
  assign o_osc_bypass = st.bypass;
  assign o_crystal_out_pin_pulldown = st.bypass;
endmodule

`default_nettype wire

//--- test/arl_properties.sv
// arl_properties: port-level checks for arl_ready_link.
// assumes one clock and the bind below; sees top ports only.
`timescale 1ns/1ps
`default_nettype none
module arl_properties
  import arl_pkg::*;
(
  input wire logic i_clk, // clock
  input wire logic i_arst_n, // reset, active low
  input wire arl_conv_t i_conv, // result pulses
  input wire logic [NCH-1:0] i_chan_off, // channel off
  input wire arl_cfg_t i_cfg, // configuration
  input wire arl_trim_wr_t i_trim, // trim write
  input wire logic i_status_rd, // status read
  input wire logic o_ready_pin_n, // ready pin
  input wire logic [NCH-1:0] o_channel_ready_flags, // flags
  input wire logic [NCH-1:0][DW-1:0] o_offset_trim, // offsets
  input wire logic o_osc_enable, // oscillator on
  input wire logic o_osc_bypass, // input buffer on
  input wire logic o_crystal_out_pin_pulldown // pin pulled low
);
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic ul;
  // unlinked, no gain hold: results land one cycle after the pulse
  assign ul = !i_cfg.ready_link_select && !i_cfg.gain_trim_enable;
  a_pin_one: assert property (!o_ready_pin_n |=> o_ready_pin_n)
    else $error("ready pin low more than one cycle");
  a_reset_flags: assert property ($rose(i_arst_n) |->
    o_channel_ready_flags == FLAGS_RESET && o_ready_pin_n)
    else $error("flags not all set after reset");
  a_read_sets: assert property (i_status_rd && ul &&
    i_conv.valid == '0 |=> o_channel_ready_flags == FLAGS_RESET)
    else $error("status read did not set flags");
  a_flags_ro: assert property (|(o_channel_ready_flags &
    ~$past(o_channel_ready_flags)) |-> $past(i_status_rd))
    else $error("flag rose without a status read");
  a_trim_keep: assert property (i_trim.wr && !i_trim.gain_sel |=>
    o_offset_trim[$past(i_trim.ch)] == $past(i_trim.word))
    else $error("offset word not stored");
  a_unlinked_pin: assert property (ul && (i_conv.valid[0] ||
    i_conv.valid[1]) |=> !o_ready_pin_n)
    else $error("pin missed channel 0 or 1 pulse");
  a_unlinked_flag: assert property (ul && i_conv.valid != '0 |=>
    (o_channel_ready_flags & $past(i_conv.valid)) == '0)
    else $error("flag not cleared by update");
  a_linked_flags: assert property (i_cfg.ready_link_select &&
    !o_ready_pin_n |-> (o_channel_ready_flags & ~i_chan_off) == '0)
    else $error("linked flags not cleared with pin");
  a_gain_hold: assert property (!i_cfg.ready_link_select &&
    i_cfg.gain_trim_enable && i_conv.valid[1] && o_ready_pin_n |=>
    o_ready_pin_n [*8])
    else $error("pin pulsed early under gain");
  a_osc_sel: assert property (
    $rose(i_cfg.external_clock_select) |=>
    o_osc_bypass && o_crystal_out_pin_pulldown && !o_osc_enable)
    else $error("clock select not applied");
endmodule
bind arl_ready_link arl_properties u_props (.i_clk, .i_arst_n, .i_conv,
  .i_chan_off, .i_cfg, .i_trim, .i_status_rd, .o_ready_pin_n,
  .o_channel_ready_flags, .o_offset_trim, .o_osc_enable, .o_osc_bypass,
  .o_crystal_out_pin_pulldown);
`default_nettype wire

//--- test/arl_host_model.sv
// arl_host_model: host that drains the sample stream, stalling at random.
// assumes the bench raises i_stall to let the buffer fill.
`timescale 1ns/1ps
`default_nettype none
module arl_host_model (
  input wire logic i_clk, // clock
  input wire logic i_stall, // hold off all reads
  input wire logic i_valid, // sample offered
  output logic o_ready, // sample taken
  output int o_pops // samples taken so far
);
  logic rdy = 1'b0;
  int cnt = 0;
  assign o_ready = rdy;
  assign o_pops = cnt;
  always @(posedge i_clk) begin
    if (i_valid && rdy)
      cnt <= cnt + 1;
    // ready moves only just after an edge
    rdy <= #1 !i_stall && ($urandom % 4 != 0);
  end
endmodule
`default_nettype wire

//--- test/arl_ready_link_bench.sv
// arl_ready_link_bench: random and corner tests of arl_ready_link.
// assumes the checker is bound in and the host model drains the stream.
`timescale 1ns/1ps
`default_nettype none
module arl_ready_link_bench;
  import arl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  arl_conv_t cv = '0;
  logic [NCH-1:0] coff = '0;
  logic [3:0][PHW-1:0] ph = '0;
  arl_cfg_t cfg = 8'h80;
  logic tk = 1'b0;
  arl_trim_wr_t tw = '0;
  logic rd = 1'b0;
  logic stall = 1'b1;
  logic pin_n, osce, byp, pdn, sv, sr;
  logic [NCH-1:0] flg, ex;
  logic [NCH-1:0][DW-1:0] dat, offs, gns;
  arl_sample_t st;
  logic [DW-1:0] hw;
  int pops, k, n, j;
  int miscompares = 0;
  int n_compared = 0;
  arl_ready_link dut (.i_clk(clk), .i_arst_n(rst_n), .i_conv(cv),
    .i_chan_off(coff), .i_pair_delay_regs(ph), .i_cfg(cfg),
    .i_mod_tick(tk), .i_trim(tw), .i_status_rd(rd), .o_ready_pin_n(pin_n),
    .o_channel_ready_flags(flg), .o_chan_data(dat), .o_offset_trim(offs),
    .o_gain_trim(gns), .o_osc_enable(osce), .o_osc_bypass(byp),
    .o_crystal_out_pin_pulldown(pdn), .o_stream_valid(sv),
    .i_stream_ready(sr), .o_stream(st));
  arl_host_model u_host (.i_clk(clk), .i_stall(stall), .i_valid(sv),
    .o_ready(sr), .o_pops(pops));
  initial forever #2.5 clk = ~clk;
  task automatic tick(int c = 1);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic cmp(logic [DW-1:0] g, logic [DW-1:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // expected corrected code; wide math so saturation is seen
  function automatic logic [DW-1:0] cor(logic [DW-1:0] raw,
      logic [DW-1:0] o, logic [DW-1:0] g, logic act);
    longint s, lim;
    s = $signed(raw);
    if (cfg.offset_trim_enable && act)
      s += $signed(o & (cfg.decimation_ratio == DEC_OSR32 ? OSR32_MASK : '1));
    if (cfg.gain_trim_enable && act)
      s = (s * ((longint'(1) <<< 23) + longint'($signed(g)))) >>> 23;
    if (cfg.res16)
      s = s >>> 8;
    lim = cfg.res16 ? 32767 : 8388607;
    if (s > lim)
      s = lim;
    if (s < -lim - 1)
      s = -lim - 1;
    return cfg.res16 ? {s[15:0], 8'h00} : s[23:0];
  endfunction
  // most lagging active channel, ties to the lowest index
  function automatic int lag();
    int b = -1;
    longint bd = 0;
    longint d;
    for (int c = 0; c < NCH; c++)
      if (!coff[c]) begin
        d = c[0] ? 0 : $signed(ph[c/2]);
        if (b < 0 || d > bd) begin
          b = c;
          bd = d;
        end
      end
    return b;
  endfunction
  initial begin
    #100000;
    $display("[ERR] %0t run too long", $time);
    miscompares++;
    finish_test();
  end
  initial begin
    void'($urandom(17518));
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(3);
    cmp(flg, FLAGS_RESET);
    cmp({osce, byp, pdn}, 3'h4);
    for (k = 0; k < 2 * NCH; k++) begin
      tw = '{1'b1, k[3], k[2:0], DW'($urandom)};
      tick();
      cmp(k[3] ? gns[k%8] : offs[k%8], tw.word);
    end
    tw.wr = 1'b0;
    cfg.ready_link_select = 1'b0;
    for (k = 0; k < 40; k++) begin
      cv.valid = NCH'($urandom);
      for (n = 0; n < NCH; n++)
        cv.data[n] = k < 2 ? (k ? SAT24_MIN : SAT24_MAX) : DW'($urandom);
      coff = NCH'($urandom);
      tk = 1'($urandom);
      cfg.offset_trim_enable = k < 2 || $urandom % 2;
      cfg.res16 = 1'($urandom);
      cfg.decimation_ratio = 3'($urandom);
      rd = $urandom % 4 == 0;
      ex = (rd ? FLAGS_RESET : flg) & ~cv.valid;
      tick();
      cmp(pin_n, !(cv.valid[0] | cv.valid[1]));
      cmp(flg, ex);
      for (n = 0; n < NCH; n++)
        if (cv.valid[n])
          cmp(dat[n], cor(cv.data[n], offs[n], gns[n], !coff[n]));
      cv.valid = '0;
      rd = 1'b0;
      tick();
    end
    cmp(sv, 1'b1);
    stall = 1'b0;
    for (n = 0; n < 400 && sv; n++)
      tick();
    cmp(sv, 1'b0);
    cmp(pops >= FIFO_DEPTH, 1'b1);
    // hold the host off so the first linked push stays at the head
    stall = 1'b1;
    rd = 1'b1;
    tick();
    rd = 1'b0;
    cmp(flg, FLAGS_RESET);
    cfg.ready_link_select = 1'b1;
    for (j = 0; j < 3; j++) begin
      for (k = 0; k < 4; k++)
        ph[k] = PHW'($urandom);
      coff = NCH'($urandom) & 8'h7e;
      for (k = 0; k < NCH; k++)
        cv.data[k] = DW'($urandom);
      n = lag();
      cv.valid = ~(8'h01 << n);
      rd = 1'b1;
      tick();
      rd = 1'b0;
      cmp(pin_n, 1'b1);
      cv.valid = 8'h01 << n;
      tick();
      cmp(pin_n, 1'b0);
      cmp(flg, coff);
      for (k = 0; k < NCH; k++)
        if (!coff[k])
          cmp(dat[k], cor(cv.data[k], offs[k], gns[k], 1'b1));
      if (j == 0)
        hw = cor(cv.data[0], offs[0], gns[0], 1'b1);
      cv.valid = '0;
      tick();
    end
    cmp(sv, 1'b1);
    cmp(st.ch, 3'h0);
    cmp(st.word, hw);
    cfg.ready_link_select = 1'b0;
    cfg.gain_trim_enable = 1'b1;
    coff = 8'h01;
    tk = 1'b1;
    cv.valid = 8'h03;
    tick();
    cv.valid = '0;
    for (n = 1; n < 60 && pin_n; n++)
      tick();
    cmp(n, 25);
    for (k = 0; k < 2; k++)
      cmp(dat[k], cor(cv.data[k], offs[k], gns[k], !coff[k]));
    cfg.gain_trim_enable = 1'b0;
    cfg.external_clock_select = 1'b1;
    tick(2);
    cmp({osce, byp, pdn}, 3'h3);
    finish_test();
  end
endmodule
`default_nettype wire
